// ===== rtl/ccb_pkg.sv
package ccb_pkg;
  // Clock
  localparam int CLK_NS = 10;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Control field positions
  localparam int CTRL_AUTO_NEWLINE = 0;
  localparam int CTRL_CURSOR_SW = 1;
  localparam int CTRL_NDS_DISABLE = 2;
  localparam int CTRL_READ_MODE = 3;
  localparam int CTRL_WIDTH = 4;
  // Status field positions
  localparam int STAT_COLUMN_LSB = 0;
  localparam int STAT_BELL = 8;
  localparam int STAT_ERASE = 9;
  localparam int STAT_INHIBIT = 10;
  localparam int STAT_UNDERFLOW = 11;
  localparam int STAT_OVERFLOW = 12;
  // Column range and special positions
  localparam logic [6:0] COL_FIRST = 7'h00;
  localparam logic [6:0] COL_LAST = 7'h4F;
  localparam logic [6:0] LINE_END_FROM = 7'h47;
  localparam logic [6:0] COL_CODE_MIN = 7'h20;
  localparam logic [6:0] COL_CODE_MAX = 7'h6F;
  localparam int VISIBLE_COLS = 80;
  // Write pulse: last four dots of a character, at least 367 ns
  localparam int WRITE_PULSE_NS = 367;
  localparam int WRITE_DOTS = 4;
  localparam int DOT_CYCLES = (WRITE_PULSE_NS + CLK_NS * WRITE_DOTS - 1) / (CLK_NS * WRITE_DOTS);
  // Tone of about 3.6 kHz, half period rounded down
  localparam int TONE_HZ = 3600;
  localparam int TONE_HALF_CYCLES = 1_000_000_000 / (2 * TONE_HZ * CLK_NS);
  // Bell duration
  localparam int BELL_MS = 100;
  localparam int BELL_CYCLES = (BELL_MS * 1_000_000) / CLK_NS;

  // Decoded character inputs, held through the character strobe
  typedef struct packed {
    logic execute_char;
    logic ctrl_char;
    logic del_char;
    logic space_char;
    logic escape_suppress;
    logic forespace_cmd;
    logic backspace_decoded;
    logic bell_code;
    logic carriage_return;
    logic line_feed;
    logic home_cmd;
    logic clear_screen;
    logic cursor_load_phase_a;
    logic cursor_load_phase_b;
    logic scroll_line_feed;
    logic cursor_on_bottom_row;
    logic initiate_transmit;
    logic [6:0] rx_data;
  } ccb_rx_t;
endpackage : ccb_pkg

// ===== rtl/ccb_column_top.sv
// Operation
// R01 - Bell timer starts on bell code with character clock, or on line end.
// R02 - Line end fires when column advances from 71 to 72.
// R03 - Running bell timer gates a 3.6 kHz tone onto the beeper.
// R04 - Read start or column overflow clears the bell timer at once.
// R05 - Column increments on written character, forespace, or readback transmit.
// R06 - Character advance for all chars except control, delete, escape-suppressed ones.
// R07 - Character strobe is execute signal ANDed with character clock pulse.
// R08 - Forespace increment is gated by character clock pulse only.
// R09 - Readback increment is read mode AND initiate transmit.
// R10 - Column decrements only on decoded backspace.
// R11 - Column clears on clear screen, carriage return, home with cursor switch.
// R12 - Decrement from column zero sets underflow and forces column zero.
// R13 - Increment past 79 sets overflow and loads the counter.
// R14 - Overflow loads zero with auto newline, else 79.
// R15 - With auto newline, overflow requests a line advance.
// R16 - Overflow load always takes the fixed value, never received data.
// R17 - Cursor load phases three and four select data; load on fourth strobe.
// R18 - Column codes 040 to 157 octal translate down by 040.
// R19 - Erase line enables 80 write pulses per line scan period.
// R20 - Otherwise one write pulse per advanced character.
// R21 - Switch open: spaces after return inhibit writes until line feed.
// R22 - Write pulse covers last four dot positions of the character.
// R23 - Scroll line feed on bottom row sets erase flag for one line.
// R24 - Column counter is seven bits, 0 to 79, updated on character clock.
`timescale 1ns/1ns
`default_nettype none
module ccb_column_top
  import ccb_pkg::*;
#(
  parameter int DOTS_PER_CHAR = 9,
  parameter int CHARS_PER_LINE = 100,
  parameter int BELL_TIME_CYCLES = ccb_pkg::BELL_CYCLES,
  parameter int TONE_HALF = ccb_pkg::TONE_HALF_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ccb_pkg::ccb_rx_t rx,
  output logic [6:0] column,
  output logic char_clock_pulse,
  output logic char_advance,
  output logic line_end,
  output logic row_advance,
  output logic beeper,
  output logic erase_line,
  output logic column_clock_phase,
  output logic mem_write
);
  import ccb_pkg::*;

  logic [CTRL_WIDTH-1:0] ctrl;
  logic [31:0] status_word;
  logic [7:0] dot_div;
  logic [7:0] dot_cnt;
  logic [7:0] char_in_line;
  logic [7:0] erase_left;
  logic erase_flag;
  logic [31:0] bell_cnt;
  logic bell_running;
  logic [31:0] tone_cnt;
  logic tone_modulator;
  logic space_inhibit;
  logic underflow;
  logic overflow;
  logic write_req;
  logic dot_tick;
  logic char_end;
  logic write_pulse_timer;
  logic char_received_strobe;
  logic advance_now;
  logic gated_forespace_inc;
  logic read_inc;
  logic column_increment;
  logic column_dec;
  logic column_clear;
  logic column_load;
  logic column_borrow;
  logic overflow_now;
  logic line_end_now;
  logic bell_timer_clear;
  logic bell_start;
  logic write_allowed;
  logic [6:0] load_value;
  logic [6:0] next_column;
  logic apb_write;

  // Dot divider: each dot spans DOT_CYCLES clocks
  assign dot_tick = (dot_div == 8'(DOT_CYCLES - 1));
  assign char_end = dot_tick && (dot_cnt == 8'(DOTS_PER_CHAR - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dot_div <= 8'h00;
    else if (dot_tick)
      dot_div <= 8'h00;
    else
      dot_div <= dot_div + 8'h01;
  end

  // Dot position within the character period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dot_cnt <= 8'h00;
    else if (char_end)
      dot_cnt <= 8'h00;
    else if (dot_tick)
      dot_cnt <= dot_cnt + 8'h01;
  end

  // Refresh column position; visible part is the column clock phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      char_in_line <= 8'h00;
    else if (char_end)
      char_in_line <= (char_in_line == 8'(CHARS_PER_LINE - 1)) ? 8'h00 : char_in_line + 8'h01;
  end

  // One-cycle character clock, registered so the output is a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      char_clock_pulse <= 1'b0;
      column_clock_phase <= 1'b0;
    end
    else
    begin
      char_clock_pulse <= char_end;
      column_clock_phase <= (char_in_line < 8'(VISIBLE_COLS));
    end
  end

  // R07 strobe from execute
  assign char_received_strobe = rx.execute_char && char_clock_pulse;
  // R06 exclusion terms
  assign advance_now = char_received_strobe && !rx.ctrl_char && !rx.del_char
                       && !rx.escape_suppress;
  // R08 forespace clock gating
  assign gated_forespace_inc = rx.forespace_cmd && char_clock_pulse;
  // R09 readback increment
  assign read_inc = ctrl[CTRL_READ_MODE] && rx.initiate_transmit && char_clock_pulse;
  // R05 three increment sources
  assign column_increment = advance_now || gated_forespace_inc || read_inc;
  // R10 backspace only
  assign column_dec = rx.backspace_decoded && char_clock_pulse;
  // R11 clear conditions
  assign column_clear = char_clock_pulse && (rx.clear_screen || rx.carriage_return
                        || (rx.home_cmd && ctrl[CTRL_CURSOR_SW]));
  // R17 load on fourth phase
  assign column_load = rx.cursor_load_phase_a && rx.cursor_load_phase_b
                       && char_received_strobe;
  // R12 borrow out of column zero
  assign column_borrow = column_dec && !column_increment && (column == COL_FIRST);
  // R13 past the last column
  assign overflow_now = column_increment && !column_dec && (column == COL_LAST);
  // R02 advance from 71 to 72
  assign line_end_now = column_increment && !column_dec && (column == LINE_END_FROM);

  // R18 column code translation, out-of-range codes clamp
  always_comb
  begin
    if (rx.rx_data < COL_CODE_MIN)
      load_value = COL_FIRST;
    else if (rx.rx_data > COL_CODE_MAX)
      load_value = COL_LAST;
    else
      load_value = rx.rx_data - COL_CODE_MIN;
  end

  // Column next value, clear has priority, then data load
  always_comb
  begin
    next_column = column;
    if (column_clear)
      next_column = COL_FIRST;
    else if (column_load)
      next_column = load_value;
    // R14 R16 fixed overflow value
    else if (overflow_now)
      next_column = ctrl[CTRL_AUTO_NEWLINE] ? COL_FIRST : COL_LAST;
    // R12 forced back to zero
    else if (column_borrow)
      next_column = COL_FIRST;
    else if (column_increment && !column_dec)
      next_column = column + 7'h01;
    else if (column_dec && !column_increment)
      next_column = column - 7'h01;
  end

  // R24 seven-bit counter on character clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      column <= COL_FIRST;
    else if (char_clock_pulse)
      column <= next_column;
  end

  // Overflow and underflow flags, one character long, plus event outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      underflow <= 1'b0;
      overflow <= 1'b0;
      line_end <= 1'b0;
      row_advance <= 1'b0;
      char_advance <= 1'b0;
    end
    else
    begin
      // R13 overflow capture
      if (char_clock_pulse)
        overflow <= overflow_now && !column_clear && !column_load;
      // R12 underflow capture
      if (char_clock_pulse)
        underflow <= column_borrow && !column_clear && !column_load;
      line_end <= line_end_now && !column_clear && !column_load;
      // R15 line advance request
      row_advance <= overflow_now && ctrl[CTRL_AUTO_NEWLINE] && !column_clear && !column_load;
      char_advance <= advance_now;
    end
  end

  // R04 clear terms; a clear beats a start in the same cycle
  assign bell_timer_clear = read_inc || (overflow_now && !column_clear && !column_load);
  // R01 trigger terms
  assign bell_start = (rx.bell_code && char_clock_pulse) || line_end_now;

  // Bell one-shot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bell_cnt <= 32'h0000_0000;
      bell_running <= 1'b0;
    end
    else if (bell_timer_clear)
    begin
      bell_cnt <= 32'h0000_0000;
      bell_running <= 1'b0;
    end
    else if (bell_start)
    begin
      bell_cnt <= 32'(BELL_TIME_CYCLES - 1);
      bell_running <= 1'b1;
    end
    else if (bell_running)
    begin
      bell_cnt <= bell_cnt - 32'h0000_0001;
      bell_running <= (bell_cnt != 32'h0000_0000);
    end
  end

  // Free-running square wave for the tone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tone_cnt <= 32'h0000_0000;
      tone_modulator <= 1'b0;
    end
    else if (tone_cnt == 32'(TONE_HALF - 1))
    begin
      tone_cnt <= 32'h0000_0000;
      tone_modulator <= !tone_modulator;
    end
    else
      tone_cnt <= tone_cnt + 32'h0000_0001;
  end

  // R03 tone gating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      beeper <= 1'b0;
    else
      beeper <= bell_running && tone_modulator;
  end

  // R23 erase flag lasts one line period of character clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      erase_flag <= 1'b0;
      erase_left <= 8'h00;
    end
    else if (char_clock_pulse && rx.scroll_line_feed && rx.cursor_on_bottom_row)
    begin
      erase_flag <= 1'b1;
      erase_left <= 8'(CHARS_PER_LINE - 1);
    end
    else if (char_clock_pulse && erase_flag)
    begin
      erase_left <= erase_left - 8'h01;
      erase_flag <= (erase_left != 8'h00);
    end
  end

  // Erase line is the flag gated by the visible column phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      erase_line <= 1'b0;
    else
      erase_line <= erase_flag && (char_in_line < 8'(VISIBLE_COLS));
  end

  // R21 space inhibit, set by return wins over line feed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      space_inhibit <= 1'b0;
    else if (char_received_strobe && rx.carriage_return)
      space_inhibit <= 1'b1;
    else if (char_received_strobe && rx.line_feed)
      space_inhibit <= 1'b0;
  end

  // R21 switch closed writes everything
  assign write_allowed = ctrl[CTRL_NDS_DISABLE] || !space_inhibit || !rx.space_char;

  // R19 R20 one write request per character period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      write_req <= 1'b0;
    else if (char_clock_pulse)
      write_req <= (advance_now && write_allowed) || erase_line;
  end

  // R22 last four dots of the character period
  assign write_pulse_timer = (dot_cnt >= 8'(DOTS_PER_CHAR - WRITE_DOTS));

  // Write strobe to display memory
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_write <= 1'b0;
    else
      mem_write <= write_req && write_pulse_timer && !char_end;
  end

  // Status word seen by software
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STAT_COLUMN_LSB +: 7] = column;
    status_word[STAT_BELL] = bell_running;
    status_word[STAT_ERASE] = erase_flag;
    status_word[STAT_INHIBIT] = space_inhibit;
    status_word[STAT_UNDERFLOW] = underflow;
    status_word[STAT_OVERFLOW] = overflow;
  end

  // APB: ready is raised in the first access cycle, so no wait states
  assign apb_write = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= CTRL_RESET[CTRL_WIDTH-1:0];
    else if (apb_write && paddr == CTRL_OFFSET)
      ctrl <= pwdata[CTRL_WIDTH-1:0];
  end

  // Answer is prepared during the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == CTRL_OFFSET || paddr == STATUS_OFFSET);
      if (psel && !penable && !pwrite && paddr == CTRL_OFFSET)
        prdata <= {{(32 - CTRL_WIDTH){1'b0}}, ctrl};
      else if (psel && !penable && !pwrite && paddr == STATUS_OFFSET)
        prdata <= status_word;
      else
        prdata <= 32'h0000_0000;
    end
  end
endmodule // ccb_column_top
`default_nettype wire

// ===== dv/ccb_column_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ccb_column_chk
  import ccb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [6:0] column,
  input wire logic char_clock_pulse,
  input wire logic char_advance,
  input wire logic line_end,
  input wire logic row_advance,
  input wire logic erase_line,
  input wire logic column_clock_phase,
  input wire logic mem_write
);
  logic [7:0] wr_len;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Strobe length so far, wraps harmlessly if stuck high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wr_len <= 8'h00;
    else
      wr_len <= mem_write ? wr_len + 8'h01 : 8'h00;
  end
  // Write strobe holds for eight cycles once started
  sequence s_write_run;
    mem_write [*8];
  endsequence
  // Column and event outputs against their causes
  chk_col_held: assert property (
    !char_clock_pulse |=> $stable(column))
    else $error("column moved between strobes");
  chk_col_range: assert property (
    column <= COL_LAST)
    else $error("column past last position");
  chk_line_end_edge: assert property (
    line_end |-> column == LINE_END_FROM + 7'h01 && $past(column) == LINE_END_FROM)
    else $error("line end without 71 to 72 step");
  chk_wrap_zero: assert property (
    row_advance |-> column == COL_FIRST && $past(column) == COL_LAST)
    else $error("row advance without wrap to zero");
  chk_adv_strobe: assert property (
    char_advance |-> $past(char_clock_pulse))
    else $error("advance without character strobe");
  chk_adv_once: assert property (
    char_advance |=> !char_advance)
    else $error("advance longer than one cycle");
  chk_wr_start: assert property (
    $rose(mem_write) |-> s_write_run)
    else $error("write strobe cut short");
  chk_wr_width: assert property (
    $fell(mem_write) |-> wr_len inside {[38:40]})
    else $error("write strobe width wrong");
  chk_erase_gate: assert property (
    erase_line |-> column_clock_phase || $past(column_clock_phase))
    else $error("erase outside visible columns");
endmodule // ccb_column_chk
bind ccb_column_top ccb_column_chk ccb_column_chk_i (
  .pclk(pclk), .presetn(presetn), .column(column),
  .char_clock_pulse(char_clock_pulse), .char_advance(char_advance),
  .line_end(line_end), .row_advance(row_advance), .erase_line(erase_line),
  .column_clock_phase(column_clock_phase), .mem_write(mem_write)
);
`default_nettype wire

// ===== dv/ccb_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module ccb_rx_model
  import ccb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic char_clock_pulse,
  input wire ccb_pkg::ccb_rx_t nxt,
  input wire logic [6:0] lag,
  output logic taken,
  output ccb_pkg::ccb_rx_t rx
);
  logic [6:0] cnt;
  // Complement after each take, toggling back to the stale decode every other cycle until the lag ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 7'h00;
      taken <= 1'b0;
      rx <= '0;
    end
    else if (char_clock_pulse)
    begin
      cnt <= lag;
      taken <= 1'b1;
      rx <= ~rx;
    end
    else
    begin
      taken <= 1'b0;
      cnt <= (cnt != 7'h00) ? cnt - 7'h01 : cnt;
      rx <= (cnt != 7'h00) ? ~rx : nxt;
    end
  end
endmodule // ccb_rx_model
`default_nettype wire

// ===== dv/ccb_column_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module ccb_column_top_test;
  import ccb_pkg::*;
  localparam ccb_rx_t EX = '{execute_char:1, default:0};
  localparam ccb_rx_t CT = '{ctrl_char:1, default:0};
  localparam ccb_rx_t DL = '{del_char:1, default:0};
  localparam ccb_rx_t SP = '{space_char:1, default:0};
  localparam ccb_rx_t ES = '{escape_suppress:1, default:0};
  localparam ccb_rx_t FS = '{forespace_cmd:1, default:0};
  localparam ccb_rx_t BS = '{backspace_decoded:1, default:0};
  localparam ccb_rx_t BL = '{bell_code:1, default:0};
  localparam ccb_rx_t CR = '{carriage_return:1, default:0};
  localparam ccb_rx_t LF = '{line_feed:1, default:0};
  localparam ccb_rx_t HM = '{home_cmd:1, default:0};
  localparam ccb_rx_t CS = '{clear_screen:1, default:0};
  localparam ccb_rx_t LD = '{cursor_load_phase_a:1, cursor_load_phase_b:1, default:0};
  localparam ccb_rx_t SC = '{scroll_line_feed:1, cursor_on_bottom_row:1, default:0};
  localparam ccb_rx_t XM = '{initiate_transmit:1, default:0};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, taken, char_clock_pulse, char_advance, line_end, row_advance;
  logic beeper, erase_line, column_clock_phase, mem_write;
  logic [6:0] column;
  logic [6:0] lag = 7'h05;
  ccb_rx_t rx;
  ccb_rx_t nxt = '0;
  logic [9:0] eq[$];
  logic [32:0] rq[$];
  logic [6:0] col = 7'h00;
  logic [6:0] ld_codes [4] = '{7'h70, 7'h10, 7'h20, 7'h45};
  logic [3:0] ctrl = 4'h0;
  logic pend = 1'b0;
  logic mw_d = 1'b0;
  logic bp_d = 1'b0;
  int err_count = 0;
  int compares = 0;
  int wr = 0;
  int beeps = 0;
  logic [31:0] v;

  ccb_column_top #(.BELL_TIME_CYCLES(2000), .TONE_HALF(4)) ccb_column_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx(rx), .column(column), .char_clock_pulse(char_clock_pulse),
    .char_advance(char_advance), .line_end(line_end), .row_advance(row_advance),
    .beeper(beeper), .erase_line(erase_line), .column_clock_phase(column_clock_phase),
    .mem_write(mem_write));
  ccb_rx_model ccb_rx_model_i (.pclk(pclk), .presetn(presetn),
    .char_clock_pulse(char_clock_pulse), .nxt(nxt), .lag(lag), .taken(taken), .rx(rx));

  // Free running 100 MHz clock
  initial
  begin
    forever #5 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp_evt(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_val(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // One APB transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      rq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask

  task automatic setc(input logic [3:0] c);
    ctrl = c;
    apb(1'b1, CTRL_OFFSET, {28'h0, c}, '0);
  endtask

  // Hands one character over and notes the expected column and events
  task automatic chr(input ccb_rx_t f, input logic [6:0] d);
    logic a;
    logic l;
    logic r;
    logic up;
    int n;
    f.rx_data = d;
    a = f.execute_char & !f.ctrl_char & !f.del_char & !f.escape_suppress;
    up = a | f.forespace_cmd | (ctrl[3] & f.initiate_transmit);
    l = 1'b0;
    r = 1'b0;
    if (f.clear_screen | f.carriage_return | (f.home_cmd & ctrl[1]))
      col = COL_FIRST;
    else if (f.cursor_load_phase_a & f.cursor_load_phase_b & f.execute_char)
      col = (d < COL_CODE_MIN) ? COL_FIRST : (d > COL_CODE_MAX) ? COL_LAST : d - COL_CODE_MIN;
    else if (up & !f.backspace_decoded)
    begin
      r = (col == COL_LAST) & ctrl[0];
      l = (col == LINE_END_FROM);
      col = (col != COL_LAST) ? col + 7'h01 : ctrl[0] ? COL_FIRST : COL_LAST;
    end
    else if (f.backspace_decoded & !up & col != COL_FIRST)
      col = col - 7'h01;
    nxt <= f;
    lag <= 7'(3 + $urandom % 60);
    eq.push_back({col, a, l, r});
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (taken !== 1'b1 && n < 300);
    if (taken !== 1'b1)
    begin
      err_count++;
      give_verdict();
    end
  endtask

  // Takes the oldest note whenever a result shows
  always @(posedge pclk)
  begin
    if (pend)
      cmp_evt({column, char_advance, line_end, row_advance}, eq.pop_front());
    pend = char_clock_pulse & presetn;
    if (psel & penable & pready & !pwrite)
      cmp_val({pslverr, prdata}, rq.pop_front());
    wr += int'(mem_write & !mw_d);
    beeps += int'(beeper & !bp_d);
    mw_d = mem_write;
    bp_d = beeper;
  end

  initial
  begin
    void'($urandom(32'hB34776A5));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    v = $urandom;
    apb(1'b1, CTRL_OFFSET, v, '0);
    apb(1'b0, CTRL_OFFSET, '0, {29'h0, v[3:0]});
    apb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF, '0);
    apb(1'b0, STATUS_OFFSET, '0, '0);
    apb(1'b0, 12'h008, '0, {1'b1, 32'h0});
    setc(4'h7);
    // Full line with auto newline: line end, wrap and one write each
    repeat (80) chr(EX, 7'(8'h21 + $urandom % 94));
    chr('0, 7'h00);
    cmp_val(33'(wr), 33'd80);
    setc(4'h6);
    chr(EX | ES | LD, 7'h6F);
    chr(EX, 7'h41);
    foreach (ld_codes[i])
      chr(EX | ES | LD, ld_codes[i]);
    chr(EX | ES | LD, 7'h10);
    chr(BS | CT, 7'h08);
    chr(EX | ES | LD, 7'h45);
    chr(BS | CT, 7'h08);
    chr(FS | CT, 7'h0C);
    chr(EX | CT, 7'h01);
    chr(EX | DL, 7'h7F);
    chr(EX | ES, 7'h33);
    chr(XM, 7'h00);
    setc(4'hE);
    chr(BL | EX | CT, 7'h07);
    beeps = 0;
    chr('0, 7'h00);
    cmp_val(33'(beeps > 0), 33'd1);
    chr(XM, 7'h00);
    // Let the last registered beeper edge pass before counting afresh
    @(posedge pclk);
    beeps = 0;
    repeat (2) chr('0, 7'h00);
    cmp_val(33'(beeps), 33'd0);
    setc(4'h4);
    chr(HM | CT | EX, 7'h1E);
    setc(4'h6);
    chr(HM | CT | EX, 7'h1E);
    chr(EX, 7'h42);
    chr(CS | EX | CT, 7'h1A);
    // Spaces after a return, switch open, then closed
    setc(4'h3);
    wr = 0;
    chr(CR | CT | EX, 7'h0D);
    chr(EX | SP, 7'h20);
    chr(LF | CT | EX, 7'h0A);
    chr(EX | SP, 7'h20);
    chr('0, 7'h00);
    cmp_val(33'(wr), 33'd1);
    setc(4'h7);
    wr = 0;
    chr(CR | CT | EX, 7'h0D);
    chr(EX | SP, 7'h20);
    chr('0, 7'h00);
    cmp_val(33'(wr), 33'd1);
    chr(SC | LF | CT | EX, 7'h0A);
    wr = 0;
    repeat (102) chr('0, 7'h00);
    cmp_val(33'(wr), 33'd80);
    give_verdict();
  end
endmodule // ccb_column_top_test
`default_nettype wire
